// *** include/pfm_pkg.sv ***
/*
  Shared constants, register map and types of the pack fault monitor.
  Assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package pfm_pkg;
  // ----------------------------------------
  // time base
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = TICK_S * CLK_HZ;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_TIMES = 8'h00;
  localparam logic [7:0] OFS_LIMITS = 8'h04;
  localparam logic [7:0] OFS_PF_EN = 8'h08;
  localparam logic [7:0] OFS_TOL = 8'h0c;
  localparam logic [7:0] OFS_ALERT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_FET_TIME = 0;
  localparam int POS_AFE_LIMIT = 8;
  localparam int POS_REC_TIME = 16;
  localparam int POS_CHK_TIME = 24;
  localparam int POS_FET_LIMIT = 0;
  localparam int POS_FUSE_LIMIT = 16;
  localparam int POS_FUSE_TIME = 24;
  localparam int POS_CNT = 8;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_FET_TIME = 8'h00;
  localparam logic [15:0] RST_FET_LIMIT = 16'h0014;
  localparam logic [7:0] RST_AFE_LIMIT = 8'h0a;
  localparam logic [7:0] RST_REC_TIME = 8'h14;
  localparam logic [7:0] RST_CHK_TIME = 8'h00;
  localparam logic [7:0] RST_FUSE_TIME = 8'h00;
  localparam logic [7:0] RST_FUSE_LIMIT = 8'h02;
  localparam logic [15:0] RST_OFS_TOL = 16'h0010;
  localparam logic [3:0] RST_PF_EN = 4'h0;

  typedef struct packed {
    logic [7:0] fet_time;
    logic [15:0] fet_limit;
    logic [7:0] afe_limit;
    logic [7:0] rec_time;
    logic [7:0] chk_time;
    logic [7:0] fuse_time;
    logic [7:0] fuse_limit;
    logic [15:0] ofs_tol;
    logic [3:0] pf_en;
  } pfm_cfg_type;

  // fault inputs from the front-end and flash controllers
  typedef struct packed {
    logic verify_fail;
    logic check_done;
    logic check_mismatch;
    logic offset_valid;
    logic [15:0] offset_value;
    logic flash_sum_fail;
    logic flash_wr_fail;
    logic flash_er_fail;
  } pfm_fe_type;

  typedef enum logic [1:0] {OFS_WAIT1, OFS_WAIT2, OFS_DONE} pfm_ofs_type;

  function automatic logic [16:0] pfm_abs(input logic signed [16:0] v);
    pfm_abs = v[16] ? 17'(-v) : 17'(v);
  endfunction
endpackage

// *** hdl/pfm_tick.sv ***
/*
  One-second tick generator for the fault monitor.
  Assumes a synchronous, already released reset.
*/
`timescale 1ns/1ps
module pfm_tick #(
  parameter int unsigned CYCLES = 40_000_000
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  output logic tick // one-cycle pulse per second
);
  import pfm_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } pfm_tick_st_type;
  pfm_tick_st_type q, d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt >= 32'(CYCLES - 1))
    begin
      d.cnt = 32'h0;
      d.tick = 1'b1;
    end
    else
      d.cnt = q.cnt + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      q <= '0;
    else
      q <= d;

  assign tick = q.tick;
endmodule // pfm_tick

// *** hdl/pfm_persist.sv ***
/*
  Persistence timer: counts seconds while its condition holds.
  A limit of zero disables it; a lapse of the condition restarts it.
*/
`timescale 1ns/1ps
module pfm_persist (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic tick, // one-second pulse
  input wire logic cond, // condition level
  input wire logic [7:0] limit, // seconds, 0 disables
  output logic running, // timing, not yet expired
  output logic expired // pulse when time is up
);
  import pfm_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic done;
    logic exp;
  } pfm_per_st_type;
  pfm_per_st_type q, d;

  always_comb
  begin
    d = q;
    d.exp = 1'b0;
    if (!cond || limit == 8'h00)
    begin
      d.cnt = 8'h00;
      d.done = 1'b0;
    end
    else if (tick && !q.done)
    begin
      if (q.cnt + 8'h01 >= limit)
      begin
        d.done = 1'b1;
        d.exp = 1'b1;
      end
      else
        d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      q <= '0;
    else
      q <= d;

  assign running = cond && limit != 8'h00 && !q.done;
  assign expired = q.exp;
endmodule // pfm_persist

// *** hdl/pfm_monitor.sv ***
/*
  Second-level permanent-failure monitor with AHB-Lite register slave.
  Assumes signed current in mA with a one-cycle measurement strobe,
  and one-cycle fault pulses from the front-end and flash controllers.
*/
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module pfm_monitor #(
  parameter int unsigned TICK_CYCLES = pfm_pkg::TICK_CYCLES
) (
  input wire logic clk_sys, // 40 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  input wire logic meas_valid, // current sample strobe
  input wire logic signed [15:0] meas_current, // mA, negative discharges
  input wire logic dsg_off_req, // firmware turned discharge fet off
  input wire logic fe_dsg_bit, // frontend discharge output bit
  input wire pfm_pkg::pfm_fe_type fe, // frontend and flash events
  output logic check_req, // start periodic frontend compare
  output logic dsg_off_cmd, // discharge fet off command pulse
  output logic safe_n, // safety output, active low
  output logic safe // complementary safety output
);
  import pfm_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pfm_cfg_type cfg;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic signed [15:0] cur;
    logic dsg_tried;
    logic dfet_cond;
    logic dfet_alert;
    logic discharge_fet_fail_flag;
    logic frontend_comm_fault;
    logic frontend_periodic_fault;
    logic dff;
    logic fuse_cond;
    logic fuse_alert;
    logic fbf;
    logic [7:0] cnt;
    logic [7:0] rec_sec;
    logic [7:0] chk_sec;
    logic chk_req;
    pfm_ofs_type ofs;
    logic [15:0] ofs_first;
    logic dsg_off;
    logic safe_n;
    logic safe;
    logic bus_rdy;
    logic bus_err;
  } pfm_st_type;
  pfm_st_type q, d;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic tick;
  logic dfet_run, dfet_exp, fuse_run, fuse_exp;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  assign rst_n = rst_sync_q[1];

  pfm_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk_sys),
    .rst_n(rst_n),
    .tick(tick)
  );

  pfm_persist u_dfet (
    .clk(clk_sys),
    .rst_n(rst_n),
    .tick(tick),
    .cond(q.dfet_cond),
    .limit(q.cfg.fet_time),
    .running(dfet_run),
    .expired(dfet_exp)
  );

  pfm_persist u_fuse (
    .clk(clk_sys),
    .rst_n(rst_n),
    .tick(tick),
    .cond(q.fuse_cond),
    .limit(q.cfg.fuse_time),
    .running(fuse_run),
    .expired(fuse_exp)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic addr_ph, inc, dec;
  logic signed [16:0] cur_x, neg_lim;
  logic [16:0] ofs_diff;
  logic [7:0] ra;

  always_comb
  begin
    d = q;
    addr_ph = hsel && hready && htrans[1];
    ra = haddr[7:0];
    cur_x = 17'(q.cur);
    neg_lim = -$signed({1'b0, q.cfg.fet_limit});
    ofs_diff = pfm_abs($signed({1'b0, q.ofs_first}) - $signed({1'b0, fe.offset_value}));
    d.dsg_off = 1'b0;
    d.chk_req = 1'b0;

    // bus: reads answer with zero wait, writes land in the data phase
    d.wr_pend = addr_ph && hwrite;
    if (addr_ph)
      d.wr_addr = ra;
    if (addr_ph && !hwrite)
    begin
      if (ra == OFS_TIMES)
        d.hrdata = {q.cfg.chk_time, q.cfg.rec_time, q.cfg.afe_limit, q.cfg.fet_time};
      else if (ra == OFS_LIMITS)
        d.hrdata = {q.cfg.fuse_time, q.cfg.fuse_limit, q.cfg.fet_limit};
      else if (ra == OFS_PF_EN)
        d.hrdata = {28'h0, q.cfg.pf_en};
      else if (ra == OFS_TOL)
        d.hrdata = {16'h0, q.cfg.ofs_tol};
      else if (ra == OFS_ALERT)
        d.hrdata = {30'h0, q.fuse_alert, q.dfet_alert};
      else if (ra == OFS_STATUS)
        d.hrdata = {16'h0, q.cnt, 3'h0, q.fbf, q.dff, q.frontend_periodic_fault, q.frontend_comm_fault, q.discharge_fet_fail_flag};
      else
        d.hrdata = 32'h0;
    end
    if (q.wr_pend)
    begin
      if (q.wr_addr == OFS_TIMES)
      begin
        d.cfg.fet_time = hwdata[POS_FET_TIME +: 8];
        d.cfg.afe_limit = hwdata[POS_AFE_LIMIT +: 8];
        d.cfg.rec_time = hwdata[POS_REC_TIME +: 8];
        d.cfg.chk_time = hwdata[POS_CHK_TIME +: 8];
      end
      else if (q.wr_addr == OFS_LIMITS)
      begin
        d.cfg.fet_limit = hwdata[POS_FET_LIMIT +: 16];
        d.cfg.fuse_limit = hwdata[POS_FUSE_LIMIT +: 8];
        d.cfg.fuse_time = hwdata[POS_FUSE_TIME +: 8];
      end
      else if (q.wr_addr == OFS_PF_EN)
        d.cfg.pf_en = hwdata[3:0];
      else if (q.wr_addr == OFS_TOL)
        d.cfg.ofs_tol = hwdata[15:0];
    end

    // ----------------------------------------
    // discharge fet fault
    // ----------------------------------------
    if (dsg_off_req)
      d.dsg_tried = 1'b1;
    if (meas_valid)
    begin
      d.cur = meas_current;
      // condition held between samples, re-evaluated on each one
      d.dfet_cond = (q.dsg_tried || dsg_off_req || fe_dsg_bit)
        && q.cfg.fet_time != 8'h00 && 17'(meas_current) <= neg_lim;
    end
    if (q.cfg.fet_time == 8'h00)
      d.dfet_cond = 1'b0;
    if (d.dfet_cond && !q.dfet_cond && !q.discharge_fet_fail_flag)
    begin
      d.dfet_alert = 1'b1;
      d.dsg_off = 1'b1;
    end
    if (!d.dfet_cond)
      d.dfet_alert = 1'b0;
    if (dfet_exp)
    begin
      d.discharge_fet_fail_flag = 1'b1;
      d.dfet_alert = 1'b0;
    end

    // ----------------------------------------
    // frontend fail counter
    // ----------------------------------------
    inc = fe.verify_fail || (fe.check_done && fe.check_mismatch);
    dec = 1'b0;
    if (tick && q.cfg.rec_time != 8'h00)
    begin
      if (q.rec_sec + 8'h01 >= q.cfg.rec_time)
      begin
        d.rec_sec = 8'h00;
        dec = 1'b1;
      end
      else
        d.rec_sec = q.rec_sec + 8'h01;
    end
    // an increment in the same cycle outweighs the recovery step
    if (inc && q.cnt != 8'hff)
      d.cnt = q.cnt + 8'h01;
    else if (dec && !inc && q.cnt != 8'h00)
      d.cnt = q.cnt - 8'h01;
    if (q.cnt > q.cfg.afe_limit)
      d.frontend_comm_fault = 1'b1;
    if (fe.check_done && fe.check_mismatch && d.cnt >= q.cfg.afe_limit)
      d.frontend_periodic_fault = 1'b1;

    // ----------------------------------------
    // offset double read after reset
    // ----------------------------------------
    case (q.ofs)
      OFS_WAIT1:
        if (fe.offset_valid)
        begin
          d.ofs_first = fe.offset_value;
          d.ofs = OFS_WAIT2;
        end
      OFS_WAIT2:
        if (fe.offset_valid)
        begin
          if (ofs_diff > {1'b0, q.cfg.ofs_tol})
            d.frontend_comm_fault = 1'b1;
          d.ofs = OFS_DONE;
        end
      default:
        d.ofs = OFS_DONE;
    endcase

    // ----------------------------------------
    // periodic verification request
    // ----------------------------------------
    if (q.cfg.chk_time == 8'h00)
      d.chk_sec = 8'h00;
    else if (tick)
    begin
      if (q.chk_sec + 8'h01 >= q.cfg.chk_time)
      begin
        d.chk_sec = 8'h00;
        d.chk_req = 1'b1;
      end
      else
        d.chk_sec = q.chk_sec + 8'h01;
    end

    // ----------------------------------------
    // flash and fuse
    // ----------------------------------------
    if (fe.flash_sum_fail || fe.flash_wr_fail || fe.flash_er_fail)
      d.dff = 1'b1;
    d.fuse_cond = (q.discharge_fet_fail_flag || q.frontend_comm_fault || q.frontend_periodic_fault || q.dff)
      && pfm_abs(cur_x) >= {9'h0, q.cfg.fuse_limit};
    d.fuse_alert = fuse_run && !fuse_exp;
    if (fuse_exp)
      d.fbf = 1'b1;

    // ----------------------------------------
    // safety outputs, latched once driven
    // ----------------------------------------
    if (|(q.cfg.pf_en & {q.dff, q.frontend_periodic_fault, q.frontend_comm_fault, q.discharge_fet_fail_flag}))
    begin
      d.safe_n = 1'b0;
      d.safe = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      q <= '0;
      q.cfg <= '{fet_time: RST_FET_TIME, fet_limit: RST_FET_LIMIT,
        afe_limit: RST_AFE_LIMIT, rec_time: RST_REC_TIME,
        chk_time: RST_CHK_TIME, fuse_time: RST_FUSE_TIME,
        fuse_limit: RST_FUSE_LIMIT, ofs_tol: RST_OFS_TOL, pf_en: RST_PF_EN};
      q.ofs <= OFS_WAIT1;
      q.safe_n <= 1'b1;
      q.bus_rdy <= 1'b1;
    end
    else
      q <= d;

  // outputs straight from state; zero-wait slave, ready and okay held from reset on
  assign hrdata = q.hrdata;
  assign hreadyout = q.bus_rdy;
  assign hresp = q.bus_err;
  assign check_req = q.chk_req;
  assign dsg_off_cmd = q.dsg_off;
  assign safe_n = q.safe_n;
  assign safe = q.safe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_safe_pair: assert property (safe_n == !safe)
    else $error("safety outputs not complementary");
  a_safe_cause: assert property (q.cfg.pf_en[0] && q.discharge_fet_fail_flag |=> !safe_n && safe)
    else $error("discharge fet fault did not trip safety");
  a_dfet_disabled: assert property (q.cfg.fet_time == 8'h00 && !q.discharge_fet_fail_flag |=> !q.discharge_fet_fail_flag)
    else $error("discharge fet fault with zero fail time");
  a_dfet_recmd: assert property ($rose(q.dfet_alert) |-> dsg_off_cmd)
    else $error("no discharge off command on first detection");
  a_dfet_clear: assert property (meas_valid && 17'(meas_current) > neg_lim
    && !dfet_exp |=> !q.dfet_alert)
    else $error("discharge alert not cleared");
  a_cnt_inc: assert property (fe.verify_fail && q.cnt != 8'hff
    |=> q.cnt == $past(q.cnt) + 8'h01)
    else $error("fail counter did not increment");
  a_comm_fail: assert property (q.cnt > q.cfg.afe_limit |=> q.frontend_comm_fault)
    else $error("communication failure not declared");
  a_chk_skip: assert property (q.cfg.chk_time == 8'h00 |=> !check_req)
    else $error("check issued with zero interval");
  a_flash_flag: assert property (fe.flash_wr_fail || fe.flash_er_fail |=> q.dff)
    else $error("flash failure flag not set");
  a_fuse_alert: assert property (fuse_exp |=> !q.fuse_alert ##1 q.fbf)
    else $error("fuse alert not cleared on expiry");

  c_dfet_fault: cover property (q.dfet_alert ##[1:500] q.discharge_fet_fail_flag);
  c_comm_fail: cover property ($rose(q.frontend_comm_fault));
  c_safe_trip: cover property ($fell(safe_n));
  c_fuse_fail: cover property ($rose(q.fbf));
endmodule // pfm_monitor

// *** verif/pfm_fe_model.sv ***
/*
  Far-side model: front-end protection IC, flash controller and current sense.
  Assumes the bench sets cur, mism and fe_dsg_bit and calls the pulse tasks.
*/
`timescale 1ns/1ps
module pfm_fe_model (
  input wire logic clk, // system clock
  input wire logic check_req, // compare request from monitor
  input wire logic dsg_off_cmd, // repeat turn-off command
  output logic meas_valid, // sample strobe every 8 cycles
  output logic signed [15:0] meas_current, // mA sample
  output pfm_pkg::pfm_fe_type fe, // event pulses
  output logic fe_dsg_bit // discharge output bit level
);
  import pfm_pkg::*;
  logic signed [15:0] cur = '0;
  logic mism = 1'b0;
  logic [2:0] ph = '0;
  logic [1:0] pend = '0;
  int n_req = 0;
  int n_cmd = 0;
  initial
  begin
    fe = '0;
    fe_dsg_bit = 1'b0;
    meas_valid = 1'b0;
    meas_current = '0;
  end
  // ----------------------------------------
  // sampling and compare answers
  // ----------------------------------------
  // between strobes the sample line flips each cycle, so a stale read matches only every other cycle
  always @(posedge clk)
  begin
    ph <= ph + 3'd1;
    meas_valid <= (ph == 3'd7);
    meas_current <= (ph == 3'd7) ? cur : ~meas_current;
    pend <= {pend[0], check_req};
    fe.check_done <= pend[1];
    fe.check_mismatch <= pend[1] ? mism : ~fe.check_mismatch;
    if (check_req)
      n_req <= n_req + 1;
    if (dsg_off_cmd)
      n_cmd <= n_cmd + 1;
  end
  // ----------------------------------------
  // event pulses
  // ----------------------------------------
  task vfail;
    @(posedge clk) fe.verify_fail <= 1'b1;
    @(posedge clk) fe.verify_fail <= 1'b0;
  endtask
  task fl(input int k);
    @(posedge clk) {fe.flash_sum_fail, fe.flash_wr_fail, fe.flash_er_fail} <= 3'b100 >> k;
    @(posedge clk) {fe.flash_sum_fail, fe.flash_wr_fail, fe.flash_er_fail} <= 3'b000;
  endtask
  task offsets(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk) {fe.offset_valid, fe.offset_value} <= {1'b1, a};
    @(posedge clk) {fe.offset_valid, fe.offset_value} <= {1'b0, ~a};
    @(posedge clk) {fe.offset_valid, fe.offset_value} <= {1'b1, b};
    @(posedge clk) {fe.offset_valid, fe.offset_value} <= {1'b0, ~b};
  endtask
endmodule // pfm_fe_model

// *** verif/tb.sv ***
/*
  Self-checking bench for the pack fault monitor over AHB-Lite.
  Assumes the far-side model and a shortened one-second tick of 20 cycles.
*/
`timescale 1ns/1ps
module tb;
  import pfm_pkg::*;
  logic clk_sys, arst_n, hsel, hwrite, dsg_off_req, hreadyout, hresp;
  logic meas_valid, fe_dsg_bit, check_req, dsg_off_cmd, safe_n, safe;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic signed [15:0] meas_current;
  pfm_fe_type fe;
  int failures = 0;
  int comparisons = 0;
  int req0;
  pfm_monitor #(.TICK_CYCLES(20)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .meas_valid(meas_valid), .meas_current(meas_current), .dsg_off_req(dsg_off_req),
    .fe_dsg_bit(fe_dsg_bit), .fe(fe), .check_req(check_req), .dsg_off_cmd(dsg_off_cmd),
    .safe_n(safe_n), .safe(safe));
  pfm_fe_model fem (.clk(clk_sys), .check_req(check_req), .dsg_off_cmd(dsg_off_cmd),
    .meas_valid(meas_valid), .meas_current(meas_current), .fe(fe), .fe_dsg_bit(fe_dsg_bit));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task final_report;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task rc(input string n, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(n, v, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task poll(input logic [31:0] m);
    v = '0;
    for (int i = 0; i < 100 && (v & m) == 0; i++)
      bus(1'b0, OFS_STATUS, 32'h0);
  endtask
  task rst(input logic [15:0] b);
    @(posedge clk_sys) arst_n <= 1'b0;
    wt(3);
    arst_n <= 1'b1;
    wt(3);
    fem.offsets(16'd100, b);
    wt(4);
  endtask
  initial
  begin
    wt(30000);
    failures++;
    final_report;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {arst_n, hsel, hwrite, haddr, htrans, hwdata, dsg_off_req} = '0;
    hsize = 3'b010;
    rst(16'd110);
    rc("times", OFS_TIMES, 32'h00140a00);
    rc("limits", OFS_LIMITS, 32'h00020014);
    rc("pf_en", OFS_PF_EN, 32'h0);
    rc("tol", OFS_TOL, 32'h10);
    rc("unmapped", 8'h40, 32'h0);
    rc("status", OFS_STATUS, 32'h0);
    bus(1'b1, OFS_PF_EN, 32'h2);
    bus(1'b1, OFS_TIMES, 32'h00000200);
    repeat (2) fem.vfail;
    wt(2);
    rc("status", OFS_STATUS, 32'h0200);
    chk("safe", {safe_n, safe}, 2'b10);
    fem.vfail;
    wt(2);
    rc("status", OFS_STATUS, 32'h0302);
    chk("safe", {safe_n, safe}, 2'b01);
    fem.fl(1);
    wt(2);
    rc("status", OFS_STATUS, 32'h030a);
    rst(16'd200);
    rc("status", OFS_STATUS, 32'h2);
    bus(1'b1, OFS_TIMES, 32'h00010a00);
    repeat (3) fem.vfail;
    rc("status", OFS_STATUS, 32'h0302);
    wt(200);
    rc("status", OFS_STATUS, 32'h0002);
    fem.fl(2);
    wt(2);
    rc("status", OFS_STATUS, 32'h000a);
    chk("safe", {safe_n, safe}, 2'b10);
    rst(16'd110);
    bus(1'b1, OFS_PF_EN, 32'h4);
    bus(1'b1, OFS_TIMES, 32'h00000200);
    req0 = fem.n_req;
    wt(100);
    chk("req_idle", fem.n_req, req0);
    @(posedge clk_sys) fem.mism <= 1'b1;
    bus(1'b1, OFS_TIMES, 32'h01000200);
    poll(32'h4);
    chk("status", v, 32'h0204);
    wt(2);
    chk("safe", {safe_n, safe}, 2'b01);
    rst(16'd110);
    bus(1'b1, OFS_PF_EN, 32'h1);
    @(posedge clk_sys) {fem.fe_dsg_bit, fem.cur} <= {1'b1, -16'sd30};
    wt(60);
    rc("alert", OFS_ALERT, 32'h0);
    // four seconds, so the clear below is seen well before the fault expires
    bus(1'b1, OFS_TIMES, 32'h00140a04);
    wt(20);
    rc("alert", OFS_ALERT, 32'h1);
    chk("off_cmd", fem.n_cmd, 1);
    @(posedge clk_sys) fem.cur <= -16'sd5;
    wt(20);
    rc("alert", OFS_ALERT, 32'h0);
    @(posedge clk_sys) {fem.fe_dsg_bit, dsg_off_req, fem.cur} <= {2'b01, -16'sd30};
    @(posedge clk_sys) dsg_off_req <= 1'b0;
    poll(32'h1);
    chk("status", v, 32'h1);
    rc("alert", OFS_ALERT, 32'h0);
    chk("safe", {safe_n, safe}, 2'b01);
    bus(1'b1, OFS_LIMITS, 32'h03020014);
    wt(6);
    bus(1'b0, OFS_ALERT, 32'h0);
    chk("fuse_alert", v & 32'h2, 32'h2);
    poll(32'h10);
    chk("status", v, 32'h11);
    rc("alert", OFS_ALERT, 32'h0);
    bus(1'b1, OFS_TIMES, 32'h00000002);
    fem.vfail;
    fem.fl(0);
    wt(2);
    rc("status", OFS_STATUS, 32'h011b);
    final_report;
  end
endmodule // tb
